//--- src/vset_a_cfg.svh
// Offsets, field positions, reset values and fixed figures of the A-set register bank.
// Function
// RQ1 - Feedback select bits enable sources independently
// RQ2 - Software never writes all-zero feedback select
// RQ3 - Config bit5 zero keeps disabled-buck pulldown
// RQ4 - Buck A-set bit7: synchronous or sleep
// RQ5 - Core bucks: 0.30 V plus 10 mV steps
// RQ6 - Processor buck: 0.53 V plus 10 mV steps
// RQ7 - Memory, IO, peripheral: 0.80 V, 20 mV steps
// RQ8 - Linear A-set bit7: normal or sleep
// RQ9 - Linear three: 0.90 V plus 20 mV steps
// RQ10 - Linear seven, eight: 0.90 V floor, 50 mV
// RQ11 - Linear nine: code zero unused, 0.95 V floor
// RQ12 - Six-bit linear codes clamp at 3.60 V
// RQ13 - Buck mode 00 follows selected set sleep
// RQ14 - B-set sleep bit applies when B selected
// RQ15 - Reserved writes never change regulator behaviour
`ifndef VSET_A_CFG_SVH
`define VSET_A_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PERIPH_BUCK_CONFIG_ADDR 8'ha2
`define CORE2_BUCK_VOLT_SET_A_ADDR 8'ha3
`define CORE1_BUCK_VOLT_SET_A_ADDR 8'ha4
`define PROCESSOR_BUCK_VOLT_SET_A_ADDR 8'ha5
`define MEMORY_BUCK_VOLT_SET_A_ADDR 8'ha6
`define IO_BUCK_VOLT_SET_A_ADDR 8'ha7
`define PERIPHERAL_BUCK_VOLT_SET_A_ADDR 8'ha8
`define LINEAR_REG3_VOLT_SET_A_ADDR 8'hab
`define LINEAR_REG7_VOLT_SET_A_ADDR 8'haf
`define LINEAR_REG8_VOLT_SET_A_ADDR 8'hb0
`define LINEAR_REG9_VOLT_SET_A_ADDR 8'hb1
`define LINEAR_REG11_VOLT_SET_A_ADDR 8'hb3

// ----------------------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------------------
`define SLEEP_SEL_BIT 7
`define MODE_MSB 7
`define MODE_LSB 6
`define PULLDOWN_OFF_BIT 5
`define FEEDBACK_MSB 2
`define FEEDBACK_LSB 0
`define MASK_SEVEN_BIT_SET 8'hff
`define MASK_SIX_BIT_SET 8'hbf
`define MASK_PERIPH_CONFIG 8'he7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VOLT_SET_A_RESET 8'h00
`define PERIPH_CONFIG_RESET 8'h01

// ----------------------------------------------------------------------------
// Voltage scales in millivolts
// ----------------------------------------------------------------------------
`define CORE_BASE_MV 12'd300
`define PROC_BASE_MV 12'd530
`define WIDE_BUCK_BASE_MV 12'd800
`define LINREG3_BASE_MV 12'd900
`define FINE_STEP_MV 12'd10
`define COARSE_STEP_MV 12'd20
`define LINREG_STEP_MV 12'd50
`define LINREG_SIX_OFFSET_MV 12'd800
`define LINREG_FLOOR_MV 12'd900
`define LINREG9_FLOOR_MV 12'd950
`define LINREG_CEIL_MV 12'd3600
`define LINREG_FLOOR_CODE 6'h03
`define LINREG_CEIL_CODE 6'h38

`endif

//--- src/vset_a_pkg.sv
// Types shared by the A-set register bank.
package vset_a_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [2:0] {
        OP_SYNC = 3'b001,
        OP_SLEEP = 3'b010,
        OP_AUTO = 3'b100
    } buck_op_t;

    typedef enum logic [3:0] {
        SCALE_CORE = 4'b0001,
        SCALE_PROC = 4'b0010,
        SCALE_WIDE = 4'b0100,
        SCALE_LIN3 = 4'b1000
    } buck_scale_t;

endpackage : vset_a_pkg

//--- src/vset_a_regs.sv
// A-set voltage and sleep register bank with peripheral buck configuration.
`include "vset_a_cfg.svh"

module vset_a_regs (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Register port from the serial control decoder
    input wire vset_a_pkg::reg_req_t i_reg_req,
    output logic [7:0] o_reg_rdata,
    // Set selection and B-set sleep bits, index 0..10 in bank order
    input wire logic [10:0] i_sel_b_set,
    input wire logic [10:0] i_b_sleep_sel,
    // Mode fields of the five other bucks, index 0..4 = core2..io
    input wire logic [4:0][1:0] i_buck_mode,
    // Regulator controls
    output vset_a_pkg::buck_op_t [5:0] o_buck_op,
    output logic [10:0][11:0] o_volt_a_mv,
    output logic [4:0] o_linreg_sleep,
    output logic o_periph_buck_pulldown_en,
    output logic [2:0] o_periph_buck_feedback_select
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [10:0][7:0] volt_set_a_r;
    logic [7:0] periph_config_r;
    logic [10:0] sleep_eff;
    logic [10:0][11:0] volt_nxt;
    logic [7:0] rdata_nxt;

    function automatic logic [3:0] slot_of(input logic [7:0] addr);
        case (addr)
            `CORE2_BUCK_VOLT_SET_A_ADDR: slot_of = 4'd0;
            `CORE1_BUCK_VOLT_SET_A_ADDR: slot_of = 4'd1;
            `PROCESSOR_BUCK_VOLT_SET_A_ADDR: slot_of = 4'd2;
            `MEMORY_BUCK_VOLT_SET_A_ADDR: slot_of = 4'd3;
            `IO_BUCK_VOLT_SET_A_ADDR: slot_of = 4'd4;
            `PERIPHERAL_BUCK_VOLT_SET_A_ADDR: slot_of = 4'd5;
            `LINEAR_REG3_VOLT_SET_A_ADDR: slot_of = 4'd6;
            `LINEAR_REG7_VOLT_SET_A_ADDR: slot_of = 4'd7;
            `LINEAR_REG8_VOLT_SET_A_ADDR: slot_of = 4'd8;
            `LINEAR_REG9_VOLT_SET_A_ADDR: slot_of = 4'd9;
            `LINEAR_REG11_VOLT_SET_A_ADDR: slot_of = 4'd10;
            default: slot_of = 4'd15;
        endcase
    endfunction : slot_of

    // Six-bit linear slots keep bit 6 as reserved and never store it.
    function automatic logic [7:0] mask_of(input logic [3:0] slot);
        if (slot >= 4'd7) begin
            mask_of = `MASK_SIX_BIT_SET;
        end else begin
            mask_of = `MASK_SEVEN_BIT_SET;
        end
    endfunction : mask_of

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Reserved addresses and bits are dropped here, so they read as zero and
    // cannot reach any regulator control.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            volt_set_a_r <= {11{`VOLT_SET_A_RESET}};
        end else if (i_reg_req.wr && slot_of(i_reg_req.addr) != 4'd15) begin
            volt_set_a_r[slot_of(i_reg_req.addr)] <=
                i_reg_req.wdata & mask_of(slot_of(i_reg_req.addr)); // RQ15
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            periph_config_r <= `PERIPH_CONFIG_RESET;
        end else if (i_reg_req.wr && i_reg_req.addr == `PERIPH_BUCK_CONFIG_ADDR) begin
            periph_config_r <= i_reg_req.wdata & `MASK_PERIPH_CONFIG; // RQ15
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_reg_req.addr == `PERIPH_BUCK_CONFIG_ADDR) begin
            rdata_nxt = periph_config_r;
        end else if (slot_of(i_reg_req.addr) != 4'd15) begin
            rdata_nxt = volt_set_a_r[slot_of(i_reg_req.addr)];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_req.rd) begin
            o_reg_rdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Voltage decode
    // ------------------------------------------------------------------------
    function automatic logic [11:0] buck_mv(input vset_a_pkg::buck_scale_t scale,
                                            input logic [6:0] code);
        logic [11:0] c;
        c = {5'h00, code};
        case (scale)
            vset_a_pkg::SCALE_CORE: buck_mv = `CORE_BASE_MV + 12'(c * `FINE_STEP_MV); // RQ5
            vset_a_pkg::SCALE_PROC: buck_mv = `PROC_BASE_MV + 12'(c * `FINE_STEP_MV); // RQ6
            vset_a_pkg::SCALE_WIDE: buck_mv =
                `WIDE_BUCK_BASE_MV + 12'(c * `COARSE_STEP_MV); // RQ7
            vset_a_pkg::SCALE_LIN3: buck_mv =
                `LINREG3_BASE_MV + 12'(c * `COARSE_STEP_MV); // RQ9
            default: buck_mv = `CORE_BASE_MV;
        endcase
    endfunction : buck_mv

    // The floor differs only for linear nine, whose code zero is unused; it
    // is driven at the floor so a stray write still gives a safe level.
    function automatic logic [11:0] linreg_mv(input logic [5:0] code,
                                              input logic [11:0] floor_mv);
        logic [11:0] c;
        c = {6'h00, code};
        if (code < `LINREG_FLOOR_CODE) begin
            linreg_mv = floor_mv; // RQ10 RQ11
        end else if (code >= `LINREG_CEIL_CODE) begin
            linreg_mv = `LINREG_CEIL_MV; // RQ12
        end else begin
            linreg_mv = `LINREG_SIX_OFFSET_MV + 12'(c * `LINREG_STEP_MV); // RQ10
        end
    endfunction : linreg_mv

    always_comb begin
        volt_nxt[0] = buck_mv(vset_a_pkg::SCALE_CORE, volt_set_a_r[0][6:0]);
        volt_nxt[1] = buck_mv(vset_a_pkg::SCALE_CORE, volt_set_a_r[1][6:0]);
        volt_nxt[2] = buck_mv(vset_a_pkg::SCALE_PROC, volt_set_a_r[2][6:0]);
        volt_nxt[3] = buck_mv(vset_a_pkg::SCALE_WIDE, volt_set_a_r[3][6:0]);
        volt_nxt[4] = buck_mv(vset_a_pkg::SCALE_WIDE, volt_set_a_r[4][6:0]);
        volt_nxt[5] = buck_mv(vset_a_pkg::SCALE_WIDE, volt_set_a_r[5][6:0]);
        volt_nxt[6] = buck_mv(vset_a_pkg::SCALE_LIN3, volt_set_a_r[6][6:0]);
        volt_nxt[7] = linreg_mv(volt_set_a_r[7][5:0], `LINREG_FLOOR_MV);
        volt_nxt[8] = linreg_mv(volt_set_a_r[8][5:0], `LINREG_FLOOR_MV);
        volt_nxt[9] = linreg_mv(volt_set_a_r[9][5:0], `LINREG9_FLOOR_MV); // RQ11
        volt_nxt[10] = linreg_mv(volt_set_a_r[10][5:0], `LINREG_FLOOR_MV);
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_volt_a_mv <= '0;
        end else begin
            o_volt_a_mv <= volt_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Sleep and mode selection
    // ------------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 11; i++) begin
            sleep_eff[i] = i_sel_b_set[i] ? i_b_sleep_sel[i] // RQ14
                                          : volt_set_a_r[i][`SLEEP_SEL_BIT]; // RQ4 RQ8
        end
    end

    function automatic vset_a_pkg::buck_op_t op_of(input logic [1:0] mode,
                                                   input logic sleep);
        case (mode)
            2'b00: op_of = sleep ? vset_a_pkg::OP_SLEEP : vset_a_pkg::OP_SYNC; // RQ13
            2'b01: op_of = vset_a_pkg::OP_SLEEP;
            2'b10: op_of = vset_a_pkg::OP_SYNC;
            default: op_of = vset_a_pkg::OP_AUTO;
        endcase
    endfunction : op_of

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 6; i++) begin
                o_buck_op[i] <= vset_a_pkg::OP_SYNC;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                o_buck_op[i] <= op_of(i_buck_mode[i], sleep_eff[i]);
            end
            o_buck_op[5] <= op_of(periph_config_r[`MODE_MSB:`MODE_LSB], sleep_eff[5]);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_linreg_sleep <= 5'h00;
        end else begin
            o_linreg_sleep <= sleep_eff[10:6]; // RQ8
        end
    end

    // ------------------------------------------------------------------------
    // Peripheral buck pulldown and feedback
    // ------------------------------------------------------------------------
    // An all-zero feedback field is passed through unchanged; guarding it is
    // left to software since no safe substitute source is defined.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_periph_buck_pulldown_en <= 1'b1;
            o_periph_buck_feedback_select <= 3'(`PERIPH_CONFIG_RESET);
        end else begin
            o_periph_buck_pulldown_en <= ~periph_config_r[`PULLDOWN_OFF_BIT]; // RQ3
            o_periph_buck_feedback_select <=
                periph_config_r[`FEEDBACK_MSB:`FEEDBACK_LSB]; // RQ1
        end
    end

endmodule : vset_a_regs

//--- verification/vset_a_regs_sva.sv
// Port checker for the A-set register bank.
module vset_a_regs_sva (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire vset_a_pkg::reg_req_t i_reg_req,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [10:0] i_sel_b_set,
    input wire logic [10:0] i_b_sleep_sel,
    input wire logic [4:0][1:0] i_buck_mode,
    input wire vset_a_pkg::buck_op_t [5:0] o_buck_op,
    input wire logic [10:0][11:0] o_volt_a_mv,
    input wire logic o_periph_buck_pulldown_en,
    input wire logic [2:0] o_periph_buck_feedback_select
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    assign w = i_reg_req.wr;
    assign a = i_reg_req.addr;
    assign d = i_reg_req.wdata;
    chk_cfg_pulldown: assert property (w && a == 8'ha2 |-> ##2
        o_periph_buck_pulldown_en == !$past(d[5], 2)) else $error("pulldown wrong");
    chk_cfg_feedback: assert property (w && a == 8'ha2 |-> ##2
        o_periph_buck_feedback_select == $past(d[2:0], 2)) else $error("feedback wrong");
    chk_core_volt: assert property (w && a == 8'ha3 |-> ##2
        o_volt_a_mv[0] == 12'd300 + 12'd10 * $past({5'h0, d[6:0]}, 2)) else $error("core mv");
    chk_proc_volt: assert property (w && a == 8'ha5 |-> ##2
        o_volt_a_mv[2] == 12'd530 + 12'd10 * $past({5'h0, d[6:0]}, 2)) else $error("proc mv");
    chk_lin_clamp: assert property (w && a == 8'haf && d[5:0] >= 6'h38 |-> ##2
        o_volt_a_mv[7] == 12'd3600) else $error("clamp wrong");
    chk_lin_floor: assert property (w && a == 8'hb0 && d[5:0] < 6'h03 |-> ##2
        o_volt_a_mv[8] == 12'd900) else $error("floor wrong");
    chk_bset_sleep: assert property (i_sel_b_set[3] && i_buck_mode[3] == 2'b00 |=>
        o_buck_op[3] == ($past(i_b_sleep_sel[3]) ? vset_a_pkg::OP_SLEEP : vset_a_pkg::OP_SYNC))
        else $error("B sleep wrong");
    chk_hole_read: assert property (i_reg_req.rd && a == 8'ha9 |=>
        o_reg_rdata == 8'h00) else $error("hole read");
    cov_cfg: cover property (w && a == 8'ha2);
    cov_clamp: cover property (w && a == 8'haf && d[5:0] >= 6'h38);
    cov_hole: cover property (i_reg_req.rd && a == 8'ha9);
endmodule : vset_a_regs_sva

bind vset_a_regs vset_a_regs_sva i_vset_a_regs_sva (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
    .i_sel_b_set(i_sel_b_set), .i_b_sleep_sel(i_b_sleep_sel), .i_buck_mode(i_buck_mode),
    .o_buck_op(o_buck_op), .o_volt_a_mv(o_volt_a_mv),
    .o_periph_buck_pulldown_en(o_periph_buck_pulldown_en),
    .o_periph_buck_feedback_select(o_periph_buck_feedback_select));

//--- verification/vset_a_regs_test.sv
// Self-checking bench for the A-set register bank.
module vset_a_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    vset_a_pkg::reg_req_t req = '0;
    logic [10:0] sel_b = '0;
    logic [10:0] b_sleep = '0;
    logic [4:0][1:0] mode = '0;
    logic [7:0] rdata;
    vset_a_pkg::buck_op_t [5:0] op;
    logic [10:0][11:0] mv;
    logic [4:0] lsleep;
    logic pd_en;
    logic [2:0] fb;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #4 i_clock = ~i_clock;
    vset_a_regs i_vset_a_regs (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_req(req),
        .o_reg_rdata(rdata), .i_sel_b_set(sel_b), .i_b_sleep_sel(b_sleep),
        .i_buck_mode(mode), .o_buck_op(op), .o_volt_a_mv(mv), .o_linreg_sleep(lsleep),
        .o_periph_buck_pulldown_en(pd_en), .o_periph_buck_feedback_select(fb));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tick;
        @(posedge i_clock);
        #1;
    endtask : tick
    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask : check
    // One strobe, then one spare edge so both read data and decoded outputs have landed.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        tick;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        tick;
        req.wr = 1'b0;
        req.rd = 1'b0;
        tick;
    endtask : access
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_reset;
        check(mv[0], 12'd300, "core reset");
        check(mv[7], 12'd900, "lin7 reset");
        check(pd_en, 1'b1, "pulldown reset");
        access(1'b0, 8'ha2, 8'h00);
        check(rdata, 8'h01, "config reset");
    endtask : s_reset
    task automatic s_bucks;
        logic [7:0] adr [7] = '{8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'hab};
        int base [7] = '{300, 300, 530, 800, 800, 800, 900};
        int step [7] = '{10, 10, 10, 20, 20, 20, 20};
        logic [6:0] code [7] = '{7'h7f, 7'h00, 7'h7f, 7'h7f, 7'h14, 7'h32, 7'h7f};
        for (int i = 0; i < 7; i++) begin
            access(1'b1, adr[i], {1'b0, code[i]});
            check(mv[i], 12'(base[i] + step[i] * code[i]), "seven-bit mv");
            access(1'b0, adr[i], 8'h00);
            check(rdata, {1'b0, code[i]}, "readback");
        end
    endtask : s_bucks
    task automatic s_linreg;
        logic [7:0] adr [10] = '{8'haf, 8'haf, 8'haf, 8'haf, 8'haf, 8'hb0, 8'hb0, 8'hb1,
            8'hb1, 8'hb3};
        int idx [10] = '{7, 7, 7, 7, 7, 8, 8, 9, 9, 10};
        logic [5:0] code [10] = '{6'h00, 6'h02, 6'h03, 6'h38, 6'h3f, 6'h14, 6'h01, 6'h01,
            6'h04, 6'h3f};
        logic [11:0] exp [10] = '{900, 900, 950, 3600, 3600, 1800, 900, 950, 1000, 3600};
        for (int i = 0; i < 10; i++) begin
            access(1'b1, adr[i], {2'b00, code[i]});
            check(mv[idx[i]], exp[i], "six-bit mv");
        end
        access(1'b1, 8'haf, 8'h45);
        check(mv[7], 12'd1050, "reserved bit six");
        access(1'b0, 8'haf, 8'h00);
        check(rdata, 8'h05, "bit six dropped");
    endtask : s_linreg
    task automatic s_config;
        logic [2:0] sel [3] = '{3'b001, 3'b010, 3'b100};
        access(1'b1, 8'ha2, 8'h41);
        check(op[5], vset_a_pkg::OP_SLEEP, "periph mode sleep");
        access(1'b1, 8'ha2, 8'hc1);
        check(op[5], vset_a_pkg::OP_AUTO, "periph mode auto");
        access(1'b1, 8'ha2, 8'h3e);
        check(pd_en, 1'b0, "pulldown off");
        check(fb, 3'b110, "feedback pair");
        access(1'b0, 8'ha2, 8'h00);
        check(rdata, 8'h26, "reserved 4:3");
        for (int i = 0; i < 3; i++) begin
            access(1'b1, 8'ha2, {5'h00, sel[i]});
            check({pd_en, fb}, {1'b1, sel[i]}, "single source");
        end
    endtask : s_config
    task automatic s_sleep;
        logic [1:0] md [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
        vset_a_pkg::buck_op_t ex [4] = '{vset_a_pkg::OP_SYNC, vset_a_pkg::OP_AUTO,
            vset_a_pkg::OP_SLEEP, vset_a_pkg::OP_SLEEP};
        access(1'b1, 8'ha3, 8'h80);
        check(op[0], vset_a_pkg::OP_SLEEP, "A sleep core");
        access(1'b1, 8'ha8, 8'h80);
        check(op[5], vset_a_pkg::OP_SLEEP, "A sleep periph");
        access(1'b1, 8'hab, 8'h80);
        check(lsleep[0], 1'b1, "A sleep linear");
        sel_b = 11'h009;
        tick;
        check({op[0], op[3]}, {vset_a_pkg::OP_SYNC, vset_a_pkg::OP_SYNC}, "B sync");
        b_sleep = 11'h009;
        tick;
        check({op[0], op[3]}, {vset_a_pkg::OP_SLEEP, vset_a_pkg::OP_SLEEP}, "B sleep");
        sel_b = '0;
        for (int i = 0; i < 4; i++) begin
            mode[0] = md[i];
            tick;
            check(op[0], ex[i], "mode field");
        end
        sel_b = '1;
        b_sleep = '1;
        tick;
        check({op[5], op[4], op[2], op[1]}, {4{vset_a_pkg::OP_SLEEP}}, "B sleep all");
        check(lsleep, 5'h1f, "B sleep linear");
        sel_b = '0;
        b_sleep = '0;
        tick;
    endtask : s_sleep
    task automatic s_reserved;
        logic [7:0] hole [3] = '{8'ha9, 8'hac, 8'hb2};
        for (int i = 0; i < 3; i++) begin
            access(1'b1, hole[i], 8'hff);
            access(1'b0, hole[i], 8'h00);
            check(rdata, 8'h00, "hole read");
        end
        check({mv[0], mv[6]}, {12'd300, 12'd900}, "holes harmless");
        check({pd_en, fb}, 4'hc, "config kept");
    endtask : s_reserved
    // ------------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------------
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("CHECK FAILED at %0t: run too long", $time);
            report_and_stop;
        end
    end
    initial begin
        repeat (8) @(posedge i_clock);
        #1;
        i_sys_rst = 1'b0;
        tick;
        s_reset;
        s_bucks;
        s_linreg;
        s_config;
        s_sleep;
        s_reserved;
        report_and_stop;
    end
endmodule : vset_a_regs_test
